// *** core/hdlc_thr_pkg.sv ***
package hdlc_thr_pkg;
   // Register offsets
   localparam logic [7:0] OFS_TEST_STATUS  = 8'h1C;
   localparam logic [7:0] OFS_FULL_LEVEL   = 8'h1D;
   localparam logic [7:0] OFS_IRQ_THRESH   = 8'h1E;
   // Field positions
   localparam int RX_BIT_CLK_POS = 3;
   localparam int TX_BIT_CLK_POS = 2;
   localparam int CRC_OK_POS     = 1;
   localparam int ADDR_OK_POS    = 0;
   localparam int RX_CODE_LSB    = 4;
   localparam int TX_CODE_LSB    = 0;
   localparam int CODE_W         = 3;
   // Threshold arithmetic
   localparam logic [7:0] FULL_STEP   = 8'h10;
   localparam logic [7:0] RXIRQ_BASE  = 8'h40;
   localparam logic [7:0] IRQ_STEP    = 8'h08;
   localparam logic [2:0] CODE_RESET  = 3'h0;
   localparam logic [2:0] SYNC_RESET  = 3'h0;

   typedef struct packed {
      logic       rx_bit_clock;
      logic       tx_bit_clock;
      logic       crc_match;
      logic       addr_match;
   } hdlc_status_t;
endpackage : hdlc_thr_pkg

// *** core/hdlc_fifo_threshold.sv ***
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hdlc_fifo_threshold
   #(parameter int OCC_W = 8)
   (
   // Clock and reset
   input  wire logic             CLK_IN,
   input  wire logic             RST_IN,
   // Register port
   input  wire logic [7:0]       ADDR_IN,
   input  wire logic [7:0]       WDATA_IN,
   input  wire logic             WR_IN,
   input  wire logic             RD_IN,
   output var  logic [7:0]       RDATA_OUT,
   // Engine status, from logic on this clock
   input  wire logic             RECEIVER_ENABLE_BIT_IN,
   input  wire logic             TRANSMITTER_ENABLE_BIT_IN,
   input  wire logic             RX_BIT_CLOCK_IN,
   input  wire logic             TX_BIT_CLOCK_IN,
   input  wire logic             CRC_MATCH_IN,
   input  wire logic             ADDR_MATCH_IN,
   // FIFO occupancy
   input  wire logic [OCC_W-1:0] RX_OCCUPANCY_IN,
   input  wire logic [OCC_W-1:0] TX_OCCUPANCY_IN,
   // Status and interrupt levels
   output var  logic             RX_FIFO_FULL_OUT,
   output var  logic             TX_FIFO_FULL_OUT,
   output var  logic             RX_FIFO_FULL_IRQ_OUT,
   output var  logic             TX_FIFO_LOW_IRQ_OUT
   );

   typedef struct packed {
      logic [2:0]               rx_full_level_code;
      logic [2:0]               tx_full_level_code;
      logic [2:0]               rx_full_irq_threshold_code;
      logic [2:0]               tx_low_irq_threshold_code;
      hdlc_thr_pkg::hdlc_status_t status;
      logic [7:0]               rdata;
      logic                     rx_full;
      logic                     tx_full;
      logic                     rx_irq;
      logic                     tx_irq;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic [OCC_W:0] rx_full_level;
   logic [OCC_W:0] tx_full_level;
   logic [OCC_W:0] rx_irq_level;
   logic [OCC_W:0] tx_irq_level;
   logic [7:0]     status_byte;

   always_comb
   begin
      state_next = state_reg;
      // Bit clocks only show once the matching side is enabled
      state_next.status.rx_bit_clock = RX_BIT_CLOCK_IN & RECEIVER_ENABLE_BIT_IN;
      state_next.status.tx_bit_clock = TX_BIT_CLOCK_IN & TRANSMITTER_ENABLE_BIT_IN;
      state_next.status.crc_match    = CRC_MATCH_IN;
      state_next.status.addr_match   = ADDR_MATCH_IN;

      rx_full_level = (OCC_W+1)'((state_reg.rx_full_level_code + 9'h001) * hdlc_thr_pkg::FULL_STEP);
      tx_full_level = (OCC_W+1)'((state_reg.tx_full_level_code + 9'h001) * hdlc_thr_pkg::FULL_STEP);
      rx_irq_level  = (OCC_W+1)'(hdlc_thr_pkg::RXIRQ_BASE
                      + state_reg.rx_full_irq_threshold_code * hdlc_thr_pkg::IRQ_STEP);
      tx_irq_level  = (OCC_W+1)'((state_reg.tx_low_irq_threshold_code + 9'h001)
                      * hdlc_thr_pkg::IRQ_STEP);

      state_next.rx_full = {1'b0, RX_OCCUPANCY_IN} >= rx_full_level;
      state_next.tx_full = {1'b0, TX_OCCUPANCY_IN} >= tx_full_level;
      state_next.rx_irq  = {1'b0, RX_OCCUPANCY_IN} >= rx_irq_level;
      state_next.tx_irq  = {1'b0, TX_OCCUPANCY_IN} <= tx_irq_level;

      // Reserved upper nibble reads zero
      status_byte = {4'h0, state_reg.status};

      if (WR_IN)
      begin
         if (ADDR_IN == hdlc_thr_pkg::OFS_FULL_LEVEL)
         begin
            state_next.rx_full_level_code =
               WDATA_IN[hdlc_thr_pkg::RX_CODE_LSB +: hdlc_thr_pkg::CODE_W];
            state_next.tx_full_level_code =
               WDATA_IN[hdlc_thr_pkg::TX_CODE_LSB +: hdlc_thr_pkg::CODE_W];
         end
         if (ADDR_IN == hdlc_thr_pkg::OFS_IRQ_THRESH)
         begin
            state_next.rx_full_irq_threshold_code =
               WDATA_IN[hdlc_thr_pkg::RX_CODE_LSB +: hdlc_thr_pkg::CODE_W];
            state_next.tx_low_irq_threshold_code =
               WDATA_IN[hdlc_thr_pkg::TX_CODE_LSB +: hdlc_thr_pkg::CODE_W];
         end
      end

      // Unmapped addresses and idle cycles read zero
      state_next.rdata = 8'h00;
      if (RD_IN)
      begin
         case (ADDR_IN)
            hdlc_thr_pkg::OFS_TEST_STATUS: state_next.rdata = status_byte;
            hdlc_thr_pkg::OFS_FULL_LEVEL:
               state_next.rdata = {1'b0, state_reg.rx_full_level_code,
                                   1'b0, state_reg.tx_full_level_code};
            hdlc_thr_pkg::OFS_IRQ_THRESH:
               state_next.rdata = {1'b0, state_reg.rx_full_irq_threshold_code,
                                   1'b0, state_reg.tx_low_irq_threshold_code};
            default: state_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign RDATA_OUT            = state_reg.rdata;
   assign RX_FIFO_FULL_OUT     = state_reg.rx_full;
   assign TX_FIFO_FULL_OUT     = state_reg.tx_full;
   assign RX_FIFO_FULL_IRQ_OUT = state_reg.rx_irq;
   assign TX_FIFO_LOW_IRQ_OUT  = state_reg.tx_irq;

   // Ends of the selectable ranges, so the bound checks hold for whatever code is set
   localparam int FULL_MIN  = int'(hdlc_thr_pkg::FULL_STEP);
   localparam int FULL_MAX  = int'(hdlc_thr_pkg::FULL_STEP) << hdlc_thr_pkg::CODE_W;
   localparam int RXIRQ_MIN = int'(hdlc_thr_pkg::RXIRQ_BASE);
   localparam int RXIRQ_MAX = int'(hdlc_thr_pkg::RXIRQ_BASE)
      + int'(hdlc_thr_pkg::IRQ_STEP) * ((1 << hdlc_thr_pkg::CODE_W) - 1);
   localparam int TXLOW_MIN = int'(hdlc_thr_pkg::IRQ_STEP);
   localparam int TXLOW_MAX = int'(hdlc_thr_pkg::IRQ_STEP) << hdlc_thr_pkg::CODE_W;

   sequence s_status_read;
      RD_IN && ADDR_IN == hdlc_thr_pkg::OFS_TEST_STATUS;
   endsequence

   a_rx_clock_view: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_status_read
      |=> RDATA_OUT[hdlc_thr_pkg::RX_BIT_CLK_POS]
          == $past(state_reg.status.rx_bit_clock))
      else $error("rx bit clock view wrong");
   a_tx_clock_view: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !TRANSMITTER_ENABLE_BIT_IN |=> !state_reg.status.tx_bit_clock)
      else $error("tx bit clock shown while disabled");
   a_crc_match_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      CRC_MATCH_IN ##1 s_status_read
      |=> RDATA_OUT[hdlc_thr_pkg::CRC_OK_POS])
      else $error("crc match not shown");
   a_addr_match_bit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !ADDR_MATCH_IN ##1 s_status_read
      |=> !RDATA_OUT[hdlc_thr_pkg::ADDR_OK_POS])
      else $error("address match shown falsely");
   a_reserved_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      s_status_read |=> RDATA_OUT[7:4] == 4'h0)
      else $error("reserved status bits nonzero");
   a_full_levels: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      WR_IN && ADDR_IN == hdlc_thr_pkg::OFS_FULL_LEVEL && WDATA_IN[6:4] == 3'h7
      ##1 RX_OCCUPANCY_IN == (OCC_W)'(127) |=> !RX_FIFO_FULL_OUT)
      else $error("rx full level wrong");
   a_tx_full_level: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      WR_IN && ADDR_IN == hdlc_thr_pkg::OFS_FULL_LEVEL && WDATA_IN[2:0] == 3'h0
      ##1 TX_OCCUPANCY_IN == (OCC_W)'(16) |=> TX_FIFO_FULL_OUT)
      else $error("tx full level wrong");
   a_rx_irq_thresh: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      WR_IN && ADDR_IN == hdlc_thr_pkg::OFS_IRQ_THRESH && WDATA_IN[6:4] == 3'h7
      ##1 RX_OCCUPANCY_IN == (OCC_W)'(119) |=> !RX_FIFO_FULL_IRQ_OUT)
      else $error("rx irq threshold wrong");
   a_tx_irq_thresh: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      WR_IN && ADDR_IN == hdlc_thr_pkg::OFS_IRQ_THRESH && WDATA_IN[2:0] == 3'h0
      ##1 TX_OCCUPANCY_IN == (OCC_W)'(9) |=> !TX_FIFO_LOW_IRQ_OUT)
      else $error("tx low threshold wrong");
   a_tx_low_empty: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      TX_OCCUPANCY_IN == '0 |=> TX_FIFO_LOW_IRQ_OUT)
      else $error("tx low irq missing when empty");
   a_rx_clock_gate: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !RECEIVER_ENABLE_BIT_IN |=> !state_reg.status.rx_bit_clock)
      else $error("rx bit clock shown while disabled");
   // A read just after reset shows the cleared status, so that case is left out
   a_rx_clock_path: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !$past(RST_IN) ##0 s_status_read
      |=> RDATA_OUT[hdlc_thr_pkg::RX_BIT_CLK_POS]
          == ($past(RX_BIT_CLOCK_IN, 2) && $past(RECEIVER_ENABLE_BIT_IN, 2)))
      else $error("rx bit clock view not gated by enable");
   a_tx_clock_path: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      !$past(RST_IN) ##0 s_status_read
      |=> RDATA_OUT[hdlc_thr_pkg::TX_BIT_CLK_POS]
          == ($past(TX_BIT_CLOCK_IN, 2) && $past(TRANSMITTER_ENABLE_BIT_IN, 2)))
      else $error("tx bit clock view not gated by enable");
   a_rx_full_floor: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(RX_OCCUPANCY_IN) < FULL_MIN |=> !RX_FIFO_FULL_OUT)
      else $error("rx full below lowest level");
   a_rx_full_ceiling: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(RX_OCCUPANCY_IN) >= FULL_MAX |=> RX_FIFO_FULL_OUT)
      else $error("rx full missing above highest level");
   a_tx_full_floor: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(TX_OCCUPANCY_IN) < FULL_MIN |=> !TX_FIFO_FULL_OUT)
      else $error("tx full below lowest level");
   a_tx_full_ceiling: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(TX_OCCUPANCY_IN) >= FULL_MAX |=> TX_FIFO_FULL_OUT)
      else $error("tx full missing above highest level");
   a_rx_irq_floor: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(RX_OCCUPANCY_IN) < RXIRQ_MIN |=> !RX_FIFO_FULL_IRQ_OUT)
      else $error("rx full irq below lowest threshold");
   a_rx_irq_ceiling: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(RX_OCCUPANCY_IN) >= RXIRQ_MAX |=> RX_FIFO_FULL_IRQ_OUT)
      else $error("rx full irq missing above highest threshold");
   a_tx_low_floor: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(TX_OCCUPANCY_IN) <= TXLOW_MIN |=> TX_FIFO_LOW_IRQ_OUT)
      else $error("tx low irq missing below lowest threshold");
   a_tx_low_ceiling: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      int'(TX_OCCUPANCY_IN) > TXLOW_MAX |=> !TX_FIFO_LOW_IRQ_OUT)
      else $error("tx low irq above highest threshold");
endmodule : hdlc_fifo_threshold
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [5:0] stat_in = 6'h00;
   logic [7:0] rx_occ = 8'h00;
   logic [7:0] tx_occ = 8'h00;
   logic [7:0] rdata;
   wire  [3:0] lvl;
   int         mismatches = 0;
   int         check_count = 0;
   int         cycles = 0;
   int         rxf, txf, rxi, txl;
   logic [3:0] stat_m, lvl_exp;
   logic [7:0] rd_exp;
   bit         started = 1'b0;

   hdlc_fifo_threshold #(.OCC_W(8)) hdlc_fifo_threshold_i (.CLK_IN(clk), .RST_IN(rst),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
      .RECEIVER_ENABLE_BIT_IN(stat_in[5]), .TRANSMITTER_ENABLE_BIT_IN(stat_in[4]),
      .RX_BIT_CLOCK_IN(stat_in[3]), .TX_BIT_CLOCK_IN(stat_in[2]), .CRC_MATCH_IN(stat_in[1]),
      .ADDR_MATCH_IN(stat_in[0]), .RX_OCCUPANCY_IN(rx_occ), .TX_OCCUPANCY_IN(tx_occ),
      .RX_FIFO_FULL_OUT(lvl[3]), .TX_FIFO_FULL_OUT(lvl[2]), .RX_FIFO_FULL_IRQ_OUT(lvl[1]),
      .TX_FIFO_LOW_IRQ_OUT(lvl[0]));

   initial forever #12.5 clk = ~clk;

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   // Occupancies cluster on multiples of eight so every threshold edge gets hit
   function automatic logic [7:0] occ_pick();
      if ($urandom % 2)
         return 8'($urandom);
      return 8'(8 * ($urandom % 16 + 1) + $urandom % 3 - 1);
   endfunction : occ_pick

   // Reference model: levels use the codes held before this edge
   always @(posedge clk)
   begin
      started <= 1'b1;
      cycles <= cycles + 1;
      if (cycles >= 5000)
      begin
         mismatches++;
         report_and_stop();
      end
      else if (rst)
      begin
         {rxf, txf, rxi, txl} = '0;
         stat_m = 4'h0;
         rd_exp = 8'h00;
         lvl_exp = 4'h0;
      end
      else
      begin
         lvl_exp = {rx_occ >= 16 * (rxf + 1), tx_occ >= 16 * (txf + 1),
                    rx_occ >= 64 + 8 * rxi, tx_occ <= 8 * (txl + 1)};
         rd_exp = 8'h00;
         if (rd && addr == 8'h1C) rd_exp = {4'h0, stat_m};
         if (rd && addr == 8'h1D) rd_exp = {1'b0, 3'(rxf), 1'b0, 3'(txf)};
         if (rd && addr == 8'h1E) rd_exp = {1'b0, 3'(rxi), 1'b0, 3'(txl)};
         if (wr && addr == 8'h1D) {rxf, txf} = {32'(wdata[6:4]), 32'(wdata[2:0])};
         if (wr && addr == 8'h1E) {rxi, txl} = {32'(wdata[6:4]), 32'(wdata[2:0])};
         stat_m = {stat_in[3] & stat_in[5], stat_in[2] & stat_in[4], stat_in[1:0]};
      end
   end

   always @(negedge clk)
      if (started)
      begin
         check("rdata", rdata, rd_exp);
         check("rx_full", 8'(lvl[3]), 8'(lvl_exp[3]));
         check("tx_full", 8'(lvl[2]), 8'(lvl_exp[2]));
         check("rx_irq", 8'(lvl[1]), 8'(lvl_exp[1]));
         check("tx_low", 8'(lvl[0]), 8'(lvl_exp[0]));
      end

   initial
   begin
      int op;
      int sel;
      void'($urandom(32));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // Directed codes and occupancies that land exactly on the threshold checks
      @(posedge clk);
      wr <= 1'b1;
      addr <= 8'h1D;
      wdata <= 8'h70;
      @(posedge clk);
      addr <= 8'h1E;
      rx_occ <= 8'h7F;
      tx_occ <= 8'h10;
      @(posedge clk);
      wr <= 1'b0;
      rx_occ <= 8'h77;
      tx_occ <= 8'h09;
      @(posedge clk);
      tx_occ <= 8'h00;
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge clk);
         op = $urandom % 3;
         sel = $urandom % 5;
         // Mid-run reset must clear the codes; bus stays quiet around it
         rst <= (i >= 1500 && i < 1502);
         wr <= (op == 1) && !(i >= 1500 && i < 1503);
         rd <= (op == 2) && !(i >= 1500 && i < 1503);
         addr <= (sel < 3) ? 8'(8'h1C + sel) : 8'($urandom);
         wdata <= 8'($urandom);
         stat_in <= 6'($urandom);
         rx_occ <= occ_pick();
         tx_occ <= occ_pick();
      end
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
